// File: rtl/usb_ep_buffer.sv
`timescale 1ns/1ns
module usb_ep_buffer #(
	parameter int ADDR_W = 9
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [ADDR_W-1:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire usb_ep_pkg::link_req_s link_req,
	output usb_ep_pkg::link_rsp_s link_rsp,
	output logic byte_drop,
	output logic receiving
);

	// ****************************************
	// Types and state
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RECV = 2'b10
	} rx_state_e;

	typedef struct packed {
		logic [usb_ep_pkg::EP_LAST:usb_ep_pkg::EP_FIRST]
			[usb_ep_pkg::REG_COUNT-1:0][7:0] regs;
		logic ack;
		logic [31:0] rdata;
		usb_ep_pkg::link_rsp_s rsp;
		logic drop;
		rx_state_e rx;
		logic [2:0] act_ep;
		logic act_y;
	} state_s;

	state_s state_q;
	state_s state_d;

	initial begin
		if (ADDR_W < 9) begin
			$error("ADDR_W must be at least 9");
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [usb_ep_pkg::FULL_W-1:0] widen(
		input logic iso,
		input logic [7:0] low,
		input logic [7:0] high
	);
		if (iso) begin
			widen = {high[usb_ep_pkg::HIGH_W-1:0],
				low[usb_ep_pkg::LOW_W-1:0]};
		end else begin
			widen = {3'h0, low[usb_ep_pkg::LOW_W-1:0]};
		end
	endfunction

	function automatic logic [7:0] write_mask(input logic [3:0] idx);
		case (idx)
			usb_ep_pkg::REG_IN_CFG,
			usb_ep_pkg::REG_OUT_CFG: write_mask = usb_ep_pkg::MASK_CFG;
			usb_ep_pkg::REG_IN_SIZE,
			usb_ep_pkg::REG_OUT_SIZE: write_mask = usb_ep_pkg::MASK_SIZE;
			usb_ep_pkg::REG_IN_SIZE_EXT,
			usb_ep_pkg::REG_OUT_X_EXT,
			usb_ep_pkg::REG_OUT_Y_EXT: write_mask = usb_ep_pkg::MASK_EXT;
			default: write_mask = usb_ep_pkg::MASK_COUNT;
		endcase
	endfunction

	function automatic logic mapped(
		input logic [2:0] ep,
		input logic [3:0] idx
	);
		mapped = (ep != 3'h0) &&
			(idx <= usb_ep_pkg::REG_OUT_Y_COUNT);
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic req;
		logic [2:0] bus_ep;
		logic [3:0] bus_idx;
		logic [2:0] e;
		logic out_dir;
		logic y;
		logic [7:0] cfg;
		logic [7:0] cnt;
		logic [7:0] ext;
		logic [3:0] cnt_idx;
		logic [3:0] ext_idx;
		logic [usb_ep_pkg::FULL_W-1:0] size;
		logic [usb_ep_pkg::FULL_W-1:0] tally;
		logic nak;
		req = 1'b0;
		bus_ep = 3'h0;
		bus_idx = 4'h0;
		e = 3'h0;
		out_dir = 1'b0;
		y = 1'b0;
		cfg = 8'h00;
		cnt = 8'h00;
		ext = 8'h00;
		cnt_idx = 4'h0;
		ext_idx = 4'h0;
		size = 10'h000;
		tally = 10'h000;
		nak = 1'b0;
		state_d = state_q;
		state_d.rsp.valid = 1'b0;
		state_d.drop = 1'b0;

		// Wishbone slave: ack one cycle after the request
		req = wb_cyc && wb_stb;
		bus_ep = wb_adr[usb_ep_pkg::ADR_EP_LSB +: 3];
		bus_idx = wb_adr[usb_ep_pkg::ADR_IDX_LSB +: 4];
		state_d.ack = req && !state_q.ack;
		if (req && !state_q.ack) begin
			if (mapped(bus_ep, bus_idx)) begin
				state_d.rdata = {24'h000000,
					state_q.regs[bus_ep][bus_idx]};
			end else begin
				state_d.rdata = 32'h00000000;
			end
		end
		// Write lands on the edge the master sees ack
		if (req && state_q.ack && wb_we && wb_sel[0] &&
			mapped(bus_ep, bus_idx)) begin
			state_d.regs[bus_ep][bus_idx] =
				wb_dat_w[7:0] & write_mask(bus_idx);
		end

		// Token handling; hardware updates win over a same-cycle write
		if (link_req.tok_valid) begin
			e = link_req.tok_ep;
			out_dir = link_req.tok_out;
			state_d.rsp.valid = 1'b1;
			if (e == 3'h0) begin
				state_d.rsp.nak = 1'b1;
				state_d.rsp.count = 10'h000;
				state_d.rsp.size = 10'h000;
			end else begin
				if (out_dir) begin
					cfg = state_q.regs[e][usb_ep_pkg::REG_OUT_CFG];
					// OUT size high bits live in the config register
					size = widen(cfg[usb_ep_pkg::CFG_ISO_BIT],
						state_q.regs[e][usb_ep_pkg::REG_OUT_SIZE],
						cfg);
				end else begin
					cfg = state_q.regs[e][usb_ep_pkg::REG_IN_CFG];
					size = widen(cfg[usb_ep_pkg::CFG_ISO_BIT],
						state_q.regs[e][usb_ep_pkg::REG_IN_SIZE],
						state_q.regs[e][usb_ep_pkg::REG_IN_SIZE_EXT]);
				end
				// Y only exists in double buffer mode
				y = link_req.tok_y && cfg[usb_ep_pkg::CFG_DOUBLE_BUFFER_SELECT_BIT];
				if (out_dir) begin
					cnt_idx = y ? usb_ep_pkg::REG_OUT_Y_COUNT :
						usb_ep_pkg::REG_OUT_X_COUNT;
				end else begin
					cnt_idx = y ? usb_ep_pkg::REG_IN_Y_COUNT :
						usb_ep_pkg::REG_IN_X_COUNT;
				end
				cnt = state_q.regs[e][cnt_idx];
				nak = !cfg[usb_ep_pkg::CFG_EN_BIT] ||
					cnt[usb_ep_pkg::CNT_NAK_BIT];
				state_d.rsp.nak = nak;
				state_d.rsp.size = size;
				if (out_dir) begin
					state_d.rsp.count = 10'h000;
				end else if (nak) begin
					state_d.rsp.count = 10'h000;
				end else begin
					// IN count high bits come from the config register
					state_d.rsp.count = widen(
						cfg[usb_ep_pkg::CFG_ISO_BIT], cnt, cfg);
				end
				if (out_dir && !nak) begin
					state_d.rx = ST_RECV;
					state_d.act_ep = e;
					state_d.act_y = y;
					ext_idx = y ? usb_ep_pkg::REG_OUT_Y_EXT :
						usb_ep_pkg::REG_OUT_X_EXT;
					state_d.regs[e][cnt_idx] = 8'h00;
					state_d.regs[e][ext_idx] = 8'h00;
				end
			end
		end

		// Received bytes and end of packet
		case (state_q.rx)
			ST_IDLE: begin
			end
			ST_RECV: begin
				e = state_q.act_ep;
				cfg = state_q.regs[e][usb_ep_pkg::REG_OUT_CFG];
				cnt_idx = state_q.act_y ? usb_ep_pkg::REG_OUT_Y_COUNT :
					usb_ep_pkg::REG_OUT_X_COUNT;
				ext_idx = state_q.act_y ? usb_ep_pkg::REG_OUT_Y_EXT :
					usb_ep_pkg::REG_OUT_X_EXT;
				cnt = state_q.regs[e][cnt_idx];
				ext = state_q.regs[e][ext_idx];
				size = widen(cfg[usb_ep_pkg::CFG_ISO_BIT],
					state_q.regs[e][usb_ep_pkg::REG_OUT_SIZE], cfg);
				tally = widen(cfg[usb_ep_pkg::CFG_ISO_BIT], cnt,
					ext);
				if (link_req.byte_valid) begin
					if (tally < size) begin
						tally = tally + 10'h001;
					end else begin
						state_d.drop = 1'b1;
					end
				end
				if (cfg[usb_ep_pkg::CFG_ISO_BIT]) begin
					state_d.regs[e][ext_idx] =
						{5'h00, tally[9:7]};
				end
				state_d.regs[e][cnt_idx] =
					{link_req.pkt_end, tally[6:0]};
				if (link_req.pkt_end) begin
					state_d.rx = ST_IDLE;
				end
			end
			default: begin
				state_d.rx = ST_IDLE;
			end
		endcase
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q <= '{
				regs: '{default: usb_ep_pkg::REG_RESET},
				ack: 1'b0,
				rdata: 32'h00000000,
				rsp: '0,
				drop: 1'b0,
				rx: ST_IDLE,
				act_ep: 3'h0,
				act_y: 1'b0
			};
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wb_ack = state_q.ack;
	assign wb_dat_r = state_q.rdata;
	assign link_rsp = state_q.rsp;
	assign byte_drop = state_q.drop;
	assign receiving = (state_q.rx == ST_RECV);

endmodule

// File: rtl/usb_ep_pkg.sv
package usb_ep_pkg;

	// ****************************************
	// Endpoint range and value widths
	// ****************************************
	localparam int EP_FIRST = 1;
	localparam int EP_LAST = 7;
	localparam int LOW_W = 7;
	localparam int HIGH_W = 3;
	localparam int FULL_W = 10;
	localparam int REG_COUNT = 11;

	// ****************************************
	// Register indices within one endpoint block
	// Byte address = ep * 64 + index * 4
	// ****************************************
	localparam logic [3:0] REG_IN_CFG = 4'h0;
	localparam logic [3:0] REG_IN_SIZE = 4'h1;
	localparam logic [3:0] REG_IN_SIZE_EXT = 4'h2;
	localparam logic [3:0] REG_IN_X_COUNT = 4'h3;
	localparam logic [3:0] REG_IN_Y_COUNT = 4'h4;
	localparam logic [3:0] REG_OUT_CFG = 4'h5;
	localparam logic [3:0] REG_OUT_SIZE = 4'h6;
	localparam logic [3:0] REG_OUT_X_EXT = 4'h7;
	localparam logic [3:0] REG_OUT_Y_EXT = 4'h8;
	localparam logic [3:0] REG_OUT_X_COUNT = 4'h9;
	localparam logic [3:0] REG_OUT_Y_COUNT = 4'hA;
	localparam int ADR_IDX_LSB = 2;
	localparam int ADR_EP_LSB = 6;

	// ****************************************
	// Field positions and write masks
	// ****************************************
	localparam int CFG_ISO_BIT = 3;
	localparam int CFG_DOUBLE_BUFFER_SELECT_BIT = 4;
	localparam int CFG_EN_BIT = 7;
	localparam int CNT_NAK_BIT = 7;
	localparam logic [7:0] MASK_CFG = 8'h9F;
	localparam logic [7:0] MASK_SIZE = 8'h7F;
	localparam logic [7:0] MASK_EXT = 8'h07;
	localparam logic [7:0] MASK_COUNT = 8'hFF;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ****************************************
	// Link side carriers
	// ****************************************
	typedef struct packed {
		logic tok_valid;
		logic tok_out;
		logic [2:0] tok_ep;
		logic tok_y;
		logic byte_valid;
		logic pkt_end;
	} link_req_s;

	typedef struct packed {
		logic valid;
		logic nak;
		logic [FULL_W-1:0] count;
		logic [FULL_W-1:0] size;
	} link_rsp_s;

endpackage

// File: testbench/usb_host_model.sv
`timescale 1ns/1ns
module usb_host_model (
	input wire logic clock,
	output usb_ep_pkg::link_req_s link_req
);
	initial link_req = '0;
	task automatic tok(input logic o, input logic y);
		@(posedge clock);
		link_req <= '{1'b1, o, 3'h1, y, 1'b0, 1'b0};
		@(posedge clock);
		link_req <= '0;
	endtask
	// One byte a cycle, end flagged with the last
	task automatic bytes(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			link_req.byte_valid <= 1'b1;
			link_req.pkt_end <= (i == n - 1);
		end
		@(posedge clock);
		link_req <= '0;
	endtask
endmodule

// File: testbench/usb_ep_buffer_monitor.sv
`timescale 1ns/1ns
module usb_ep_buffer_monitor (
	input wire logic clock,
	input wire logic rstn,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic [31:0] wb_dat_r,
	input wire logic wb_ack,
	input wire usb_ep_pkg::link_req_s link_req,
	input wire usb_ep_pkg::link_rsp_s link_rsp,
	input wire logic byte_drop,
	input wire logic receiving
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_out;
		link_req.tok_valid && link_req.tok_out;
	endsequence
	sequence s_end;
		receiving && link_req.pkt_end && !link_req.tok_valid;
	endsequence
	a_ack_next: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
		else $error("ack missing");
	a_ack_pulse: assert property (wb_ack |=> !wb_ack)
		else $error("ack too long");
	a_rdat_high: assert property (wb_ack |-> wb_dat_r[31:8] == 24'h000000)
		else $error("read data high bits set");
	a_rsp_time: assert property (link_req.tok_valid |=> link_rsp.valid)
		else $error("token not answered");
	a_rsp_only: assert property (!link_req.tok_valid |=> !link_rsp.valid)
		else $error("answer without token");
	a_nak_count: assert property (link_rsp.valid && link_rsp.nak |->
		link_rsp.count == 10'h000) else $error("count sent on nak");
	a_out_count: assert property (s_out |=> link_rsp.count == 10'h000)
		else $error("count on out token");
	a_recv_rise: assert property ($rose(receiving) |->
		$past(link_req.tok_valid && link_req.tok_out))
		else $error("tally without token");
	a_recv_end: assert property (s_end |=> !receiving)
		else $error("tally not ended");
	a_drop_src: assert property (byte_drop |->
		$past(link_req.byte_valid && receiving)) else $error("bad drop");
	a_size_hold: assert property (!link_req.tok_valid |=>
		$stable(link_rsp.size)) else $error("size moved");
endmodule
bind usb_ep_buffer usb_ep_buffer_monitor mon (.clock(clock), .rstn(rstn),
	.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
	.link_req(link_req), .link_rsp(link_rsp), .byte_drop(byte_drop),
	.receiving(receiving));

// File: testbench/usb_endpoint_buffer_sizing_bench.sv
`timescale 1ns/1ns
module usb_endpoint_buffer_sizing_bench;
	typedef struct packed {
		logic y;
		logic [7:0] cfg, buffer_size_low, ext, cnt;
		logic [9:0] sz, ct;
	} row_s;
	// Non-isochronous sizes stay within 8 to 64
	row_s rows [4] = '{
		{1'b0, 8'h80, 8'h40, 8'h05, 8'h20, 10'h040, 10'h020},
		{1'b0, 8'h8D, 8'h7F, 8'h07, 8'h01, 10'h3FF, 10'h281},
		{1'b1, 8'h9C, 8'h08, 8'h01, 8'h03, 10'h088, 10'h203},
		{1'b1, 8'h94, 8'h10, 8'h03, 8'h05, 10'h010, 10'h005}};
	row_s r;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic cs = 1'b0;
	logic we = 1'b0;
	logic [8:0] adr = 9'h000;
	logic [31:0] dw = 32'h00000000;
	logic [31:0] q, wb_dat_r;
	logic wb_ack, byte_drop, receiving;
	usb_ep_pkg::link_req_s link_req;
	usb_ep_pkg::link_rsp_s link_rsp;
	int error_cnt = 0;
	int tests_run = 0;
	int drops = 0;
	always #5 clock = ~clock;
	always @(posedge clock) if (byte_drop === 1'b1) drops <= drops + 1;
	usb_ep_buffer uut (.clock(clock), .rstn(rstn), .wb_cyc(cs), .wb_stb(cs),
		.wb_we(we), .wb_adr(adr), .wb_sel(4'h1), .wb_dat_w(dw),
		.wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .link_req(link_req),
		.link_rsp(link_rsp), .byte_drop(byte_drop), .receiving(receiving));
	usb_host_model host (.clock(clock), .link_req(link_req));
	function automatic logic [8:0] a(input logic [3:0] i);
		return {3'h1, i, 2'h0};
	endfunction
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic bus(input logic [8:0] ad, input logic w, input logic [7:0] d);
		@(posedge clock);
		cs <= 1'b1;
		we <= w;
		adr <= ad;
		dw <= {24'h000000, d};
		do @(posedge clock); while (wb_ack !== 1'b1);
		q = wb_dat_r;
		cs <= 1'b0;
	endtask
	task automatic wr(input logic [8:0] ad, input logic [7:0] d);
		bus(ad, 1'b1, d);
	endtask
	task automatic rc(input logic [8:0] ad, input logic [7:0] e);
		bus(ad, 1'b0, 8'h00);
		chk({24'h000000, e}, q);
	endtask
	task automatic report_and_stop;
		if (error_cnt == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		rc(a(4'h1), 8'h00);
		for (int k = 0; k < 4; k++) begin
			r = rows[k];
			wr(a(4'h0), r.cfg);
			wr(a(4'h1), r.buffer_size_low);
			wr(a(4'h2), r.ext);
			wr(a(r.y ? 4'h4 : 4'h3), r.cnt);
			host.tok(1'b0, r.y);
			#1;
			chk(32'(r.sz), 32'(link_rsp.size));
			chk(32'(r.ct), 32'(link_rsp.count));
		end
		wr(a(4'h2), 8'hFF);
		rc(a(4'h2), 8'h07);
		wr(a(4'h1), 8'hFF);
		rc(a(4'h1), 8'h7F);
		wr(9'h004, 8'h5A);
		rc(9'h004, 8'h00);
		wr(a(4'h5), 8'h89);
		wr(a(4'h6), 8'h01);
		host.tok(1'b1, 1'b0);
		#1;
		chk(32'h00000081, 32'(link_rsp.size));
		host.bytes(130);
		repeat (2) @(posedge clock);
		chk(32'h00000001, 32'(drops));
		rc(a(4'h9), 8'h81);
		rc(a(4'h7), 8'h01);
		report_and_stop();
	end
endmodule
